// file: logic/vds_map.svh
// Register offsets, field positions, reset values and timing counts of the valve scheduler
`ifndef VDS_MAP_SVH
`define VDS_MAP_SVH
// ==========================================
// Register offsets (word index on the plain port)
`define VDS_ADDR_CONTROL 8'h00
`define VDS_ADDR_FORCE 8'h01
`define VDS_ADDR_STATUS 8'h02
`define VDS_ADDR_WEEKDAY 8'h03
`define VDS_ADDR_HOUR 8'h04
`define VDS_ADDR_MINUTE 8'h05
`define VDS_ADDR_LEN0 8'h06
`define VDS_ADDR_LEN1 8'h07
`define VDS_ADDR_LEN2 8'h08
// ==========================================
// Control fields
`define VDS_CTL_CLEAR_BIT 0
`define VDS_CTL_OVERRIDE_BIT 1
// ==========================================
// Factory defaults
`define VDS_DEF_HOUR 16'h0016
`define VDS_DEF_MINUTE 16'h001E
`define VDS_DEF_LEN 16'h00B4
`define VDS_DEF_WEEKDAY 21'h02_0202
// ==========================================
// Timing
`define VDS_MIN_PER_DAY 16'h05A0
`endif

// file: logic/vds_pkg.sv
// Types shared by the valve scheduler files
package vds_pkg;
   // Time of day and weekday from the UTC clock source
   typedef struct packed {
      logic [4:0] hour;
      logic [5:0] minute;
      logic [2:0] weekday;
      logic minute_tick;
   } vds_time_s;
   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } vds_req_s;
   typedef enum logic [2:0] {
      VDS_IDLE = 3'b001,
      VDS_OPEN = 3'b010,
      VDS_HOLD = 3'b100
   } vds_state_e;
endpackage

// file: logic/vds_valve_slot.sv
// One valve's schedule timer: open on the start minute, count the duration, then close
`timescale 1ns/10ps
`include "vds_map.svh"
module vds_valve_slot (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Schedule inputs
   input wire logic start_hit,
   input wire logic day_on,
   input wire logic minute_tick,
   input wire logic [15:0] length_min,
   input wire logic suspend,
   // Sequencing grants and request flags
   input wire logic open_grant,
   input wire logic close_grant,
   output logic open_req,
   output logic close_req,
   output logic is_open
);
   vds_pkg::vds_state_e state_reg;
   vds_pkg::vds_state_e state_next;
   logic [15:0] left_reg;
   logic [15:0] left_next;
   wire logic expired = (left_reg == 16'h0000);
   assign open_req = (state_reg == vds_pkg::VDS_OPEN);
   assign close_req = (state_reg == vds_pkg::VDS_HOLD) && expired;
   assign is_open = (state_reg == vds_pkg::VDS_HOLD);
   always_comb begin
      state_next = state_reg;
      left_next = left_reg;
      unique case (state_reg)
         vds_pkg::VDS_IDLE: begin
            if (start_hit && day_on && !suspend) begin // R7 R19
               state_next = vds_pkg::VDS_OPEN;
            end
         end
         vds_pkg::VDS_OPEN: begin
            if (suspend) begin
               state_next = vds_pkg::VDS_IDLE;
            end else if (open_grant) begin // R10
               state_next = vds_pkg::VDS_HOLD;
               left_next = length_min;
            end
         end
         vds_pkg::VDS_HOLD: begin
            if (suspend) begin
               state_next = vds_pkg::VDS_IDLE;
            end else if (expired) begin
               if (close_grant) begin // R9
                  state_next = vds_pkg::VDS_IDLE;
               end
            end else if (minute_tick) begin // R8
               left_next = left_reg - 16'h0001;
            end
         end
         default: begin
            state_next = vds_pkg::VDS_IDLE;
         end
      endcase
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= vds_pkg::VDS_IDLE;
         left_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         left_reg <= left_next;
      end
   end
endmodule

// file: logic/vds_seq.sv
// Grants one request per cycle, lowest valve number first
`timescale 1ns/10ps
module vds_seq #(
   parameter int N = 3
) (
   // Requests and one-hot grant
   input wire logic [N-1:0] req,
   output logic [N-1:0] grant
);
   // Lowest set bit wins, so valve 1 goes before 2 before 3
   assign grant = req & (~req + {{(N-1){1'b0}}, 1'b1});
endmodule

// file: logic/vds_top.sv
// Weekday valve scheduler: registers, start detection, sequencing and outputs
// How it works
// (R1) Writing one to the clear control erases every weekday enable.
// (R2) Override on makes the block ignore all scheduled opens and closes.
// (R3) Override on drives each valve straight from its force command bit while supply is not low.
// (R4) Override lamp is lit exactly while override is on.
// (R5) Any-open lamp is lit while at least one valve is open.
// (R6) Status register shows each valve position, one meaning open.
// (R7) Enabled weekday and matching start hour and minute open the valve.
// (R8) Valve stays open for its programmed minutes, then closes.
// (R9) Simultaneous closes happen one per cycle, valve 1 then 2 then 3.
// (R10) Simultaneous opens happen one per cycle, valve 1 then 2 then 3.
// (R11) One start hour is shared by all three valves.
// (R12) Start time is compared with the UTC clock input.
// (R13) Operator should keep durations at or below 1440 minutes.
// (R14) Activity lamp is lit while the control loop runs.
// (R15) Reset default is automatic mode with override cleared.
// (R16) Reset schedule: valve 1 Monday, 2 Tuesday, 3 Wednesday, 22:30, 180 min.
// (R17) Mode is held across restarts by the retained mode input.
// (R18) Low supply closes all valves until the indication clears.
// (R19) Each valve is timed independently; several may be open at once.
// (R20) A start fires once per matching minute, not again within it.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "vds_map.svh"
module vds_top #(
   parameter int NV = 3
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Register port
   input wire vds_pkg::vds_req_s bus_req,
   output logic [15:0] rdata,
   // UTC time source
   input wire vds_pkg::vds_time_s utc_time,
   // Retained mode from non-volatile storage, taken after reset
   input wire logic saved_override,
   // Supply supervisor, high while supply is low
   input wire logic low_supply,
   // Valve drives
   output logic [NV-1:0] valve_drive,
   // Lamps
   output logic activity_lamp,
   output logic override_lamp,
   output logic any_open_lamp,
   // Current override mode, for storage
   output logic override_saved
);
   // ==========================================
   // Registers
   logic override_select_reg;
   logic [NV-1:0] valve_force_cmd_reg;
   logic [7*NV-1:0] weekday_enable_reg;
   logic [15:0] open_time_hour_reg;
   logic [15:0] open_time_minute_reg;
   logic [15:0] open_length_minutes_reg [NV];
   logic [15:0] rdata_reg;
   logic [NV-1:0] valve_drive_reg;
   logic activity_lamp_reg;
   logic override_lamp_reg;
   logic any_open_lamp_reg;
   logic strap_done_reg;
   logic fired_reg;
   // ==========================================
   // Decode
   wire logic wr_ctl = bus_req.wr && (bus_req.addr == `VDS_ADDR_CONTROL);
   wire logic wr_force = bus_req.wr && (bus_req.addr == `VDS_ADDR_FORCE);
   wire logic wr_week = bus_req.wr && (bus_req.addr == `VDS_ADDR_WEEKDAY);
   wire logic wr_hour = bus_req.wr && (bus_req.addr == `VDS_ADDR_HOUR);
   wire logic wr_min = bus_req.wr && (bus_req.addr == `VDS_ADDR_MINUTE);
   wire logic clear_hit = wr_ctl && bus_req.wdata[`VDS_CTL_CLEAR_BIT];
   wire logic [NV-1:0] wr_len;
   assign wr_len[0] = bus_req.wr && (bus_req.addr == `VDS_ADDR_LEN0);
   assign wr_len[1] = bus_req.wr && (bus_req.addr == `VDS_ADDR_LEN1);
   assign wr_len[2] = bus_req.wr && (bus_req.addr == `VDS_ADDR_LEN2);
   // ==========================================
   // Start detection
   wire logic time_match = (open_time_hour_reg == {11'h000, utc_time.hour}) // R11 R12
      && (open_time_minute_reg == {10'h000, utc_time.minute});
   // Edge of the match so a start fires once per minute
   wire logic start_hit = time_match && !fired_reg; // R20
   wire logic suspend = override_select_reg || low_supply; // R2 R18
   // ==========================================
   // Valve slots
   wire logic [NV-1:0] open_req;
   wire logic [NV-1:0] close_req;
   wire logic [NV-1:0] open_grant;
   wire logic [NV-1:0] close_grant;
   wire logic [NV-1:0] is_open;
   wire logic [NV-1:0] day_on;
   vds_seq #(.N(NV)) u_open_seq (
      .req(open_req),
      .grant(open_grant)
   ); // R10
   vds_seq #(.N(NV)) u_close_seq (
      .req(close_req),
      .grant(close_grant)
   ); // R9
   genvar gi;
   generate
      for (gi = 0; gi < NV; gi++) begin : g_slot
         assign day_on[gi] = weekday_enable_reg[7*gi + utc_time.weekday];
         vds_valve_slot u_slot (
            .core_clk(core_clk),
            .resetn(resetn),
            .start_hit(start_hit),
            .day_on(day_on[gi]),
            .minute_tick(utc_time.minute_tick),
            .length_min(open_length_minutes_reg[gi]),
            .suspend(suspend),
            .open_grant(open_grant[gi]),
            .close_grant(close_grant[gi]),
            .open_req(open_req[gi]),
            .close_req(close_req[gi]),
            .is_open(is_open[gi])
         );
      end
   endgenerate
   // ==========================================
   // Valve drive selection
   wire logic [NV-1:0] drive_next = low_supply ? {NV{1'b0}} // R18
      : override_select_reg ? valve_force_cmd_reg // R3
      : is_open;
   // ==========================================
   // Read mux
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;
      unique case (bus_req.addr)
         `VDS_ADDR_CONTROL: rd_mux = {14'h0000, override_select_reg, 1'b0};
         `VDS_ADDR_FORCE: rd_mux = {13'h0000, valve_force_cmd_reg};
         `VDS_ADDR_STATUS: rd_mux = {13'h0000, valve_drive_reg}; // R6
         `VDS_ADDR_WEEKDAY: rd_mux = weekday_enable_reg[15:0];
         `VDS_ADDR_HOUR: rd_mux = open_time_hour_reg;
         `VDS_ADDR_MINUTE: rd_mux = open_time_minute_reg;
         `VDS_ADDR_LEN0: rd_mux = open_length_minutes_reg[0];
         `VDS_ADDR_LEN1: rd_mux = open_length_minutes_reg[1];
         `VDS_ADDR_LEN2: rd_mux = open_length_minutes_reg[2];
         default: rd_mux = 16'h0000;
      endcase
   end
   // Weekday bits above 15 read through the force address upper half
   wire logic [15:0] rd_value = (bus_req.addr == `VDS_ADDR_FORCE)
      ? {weekday_enable_reg[20:16], 8'h00, valve_force_cmd_reg} : rd_mux;
   // ==========================================
   // Control and schedule registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         override_select_reg <= 1'b0; // R15
         strap_done_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         override_select_reg <= saved_override; // R17
         strap_done_reg <= 1'b1;
      end else if (wr_ctl) begin
         override_select_reg <= bus_req.wdata[`VDS_CTL_OVERRIDE_BIT];
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         weekday_enable_reg <= `VDS_DEF_WEEKDAY; // R16
      end else if (clear_hit) begin
         weekday_enable_reg <= 21'h00_0000; // R1
      end else if (wr_week) begin
         weekday_enable_reg[15:0] <= bus_req.wdata;
      end else if (wr_force) begin
         weekday_enable_reg[20:16] <= bus_req.wdata[15:11];
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         valve_force_cmd_reg <= {NV{1'b0}};
         open_time_hour_reg <= `VDS_DEF_HOUR; // R16
         open_time_minute_reg <= `VDS_DEF_MINUTE;
      end else begin
         if (wr_force) begin
            valve_force_cmd_reg <= bus_req.wdata[NV-1:0];
         end
         if (wr_hour) begin
            open_time_hour_reg <= bus_req.wdata; // R11
         end
         if (wr_min) begin
            open_time_minute_reg <= bus_req.wdata;
         end
      end
   end
   generate
      for (gi = 0; gi < NV; gi++) begin : g_len
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               open_length_minutes_reg[gi] <= `VDS_DEF_LEN; // R16
            end else if (wr_len[gi]) begin
               // Values above a day are stored as given; the operator keeps them in range
               open_length_minutes_reg[gi] <= bus_req.wdata; // R13
            end
         end
      end
   endgenerate
   // ==========================================
   // Start latch, outputs and lamps
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fired_reg <= 1'b0;
         rdata_reg <= 16'h0000;
         valve_drive_reg <= {NV{1'b0}};
         activity_lamp_reg <= 1'b0;
         override_lamp_reg <= 1'b0;
         any_open_lamp_reg <= 1'b0;
      end else begin
         fired_reg <= time_match; // R20
         rdata_reg <= bus_req.rd ? rd_value : 16'h0000;
         valve_drive_reg <= drive_next;
         activity_lamp_reg <= 1'b1; // R14
         override_lamp_reg <= override_select_reg; // R4
         any_open_lamp_reg <= |drive_next; // R5
      end
   end
   assign rdata = rdata_reg;
   assign valve_drive = valve_drive_reg;
   assign activity_lamp = activity_lamp_reg;
   assign override_lamp = override_lamp_reg;
   assign any_open_lamp = any_open_lamp_reg;
   assign override_saved = override_select_reg;
endmodule

// file: tb/vds_top_checker.sv
// Port-level assertions for the valve scheduler
`timescale 1ns/10ps
`include "vds_map.svh"
module vds_top_checker #(
   parameter int NV = 3
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Register port and time
   input wire vds_pkg::vds_req_s bus_req,
   input wire logic [15:0] rdata,
   input wire vds_pkg::vds_time_s utc_time,
   input wire logic saved_override,
   input wire logic low_supply,
   // Drives and lamps
   input wire logic [NV-1:0] valve_drive,
   input wire logic activity_lamp,
   input wire logic override_lamp,
   input wire logic any_open_lamp,
   input wire logic override_saved
);
   // ==========================================
   // Helpers
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic [1:0] calm_reg;
   // Forced or low-supply drives may jump several bits; only count schedule-only spans
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) calm_reg <= 2'h0;
      else if (override_saved || low_supply) calm_reg <= 2'h0;
      else if (calm_reg != 2'h3) calm_reg <= calm_reg + 2'h1;
   end
   sequence force_wr_s;
      bus_req.wr && bus_req.addr == `VDS_ADDR_FORCE && override_saved && !low_supply;
   endsequence
   sequence status_rd_s;
      bus_req.rd && bus_req.addr == `VDS_ADDR_STATUS;
   endsequence
   // ==========================================
   // Assertions
   lamp_override_a: assert property (override_lamp == $past(override_saved))
      else $error("override lamp differs from mode");
   any_open_a: assert property (any_open_lamp == |valve_drive)
      else $error("any-open lamp differs from drives");
   force_follow_a: assert property (force_wr_s ##1 !low_supply |=>
      valve_drive == $past(bus_req.wdata[NV-1:0], 2))
      else $error("drive does not follow force command");
   low_close_a: assert property (low_supply |=> valve_drive == '0)
      else $error("valve open during low supply");
   one_change_a: assert property (calm_reg == 2'h3 |->
      $countones(valve_drive ^ $past(valve_drive)) <= 1)
      else $error("several valves changed in one cycle");
   rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 16'h0000)
      else $error("read data outside read answer");
   status_read_a: assert property (status_rd_s |=>
      rdata[NV-1:0] == $past(valve_drive) && rdata[15:NV] == '0)
      else $error("status read differs from drives");
   activity_a: assert property ($past(resetn) |-> activity_lamp)
      else $error("activity lamp dark while running");
endmodule

bind vds_top vds_top_checker #(.NV(NV)) i_vds_top_checker (.core_clk, .resetn, .bus_req,
   .rdata, .utc_time, .saved_override, .low_supply, .valve_drive, .activity_lamp,
   .override_lamp, .any_open_lamp, .override_saved);

// file: tb/vds_utc_src.sv
// UTC time-of-day source in front of the scheduler
`timescale 1ns/10ps
module vds_utc_src (
   // Clock
   input wire logic core_clk,
   // Time to the scheduler
   output vds_pkg::vds_time_s utc_time
);
   // ==========================================
   // Time control
   initial utc_time = '0;
   // A resync moves the time without a minute tick
   task set_time(input logic [4:0] h, input logic [5:0] m, input logic [2:0] d);
      @(posedge core_clk);
      utc_time.hour <= h;
      utc_time.minute <= m;
      utc_time.weekday <= d;
   endtask
   // Minute advance and tick land together; tick stands one cycle
   task tick;
      @(posedge core_clk);
      utc_time.minute_tick <= 1'b1;
      utc_time.minute <= utc_time.minute + 6'h01;
      @(posedge core_clk);
      utc_time.minute_tick <= 1'b0;
   endtask
endmodule

// file: tb/vds_top_tb.sv
// Self-checking bench for the valve scheduler
`timescale 1ns/10ps
`include "vds_map.svh"
module vds_top_tb;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   vds_pkg::vds_req_s bus_req = '0;
   logic saved_override = 1'b0;
   logic low_supply = 1'b0;
   logic [15:0] rdata;
   vds_pkg::vds_time_s utc_time;
   logic [2:0] valve_drive;
   logic activity_lamp, override_lamp, any_open_lamp, override_saved;
   int bad_count = 0;
   int checks = 0;
   always #5 core_clk = ~core_clk;
   vds_utc_src i_vds_utc_src (.core_clk, .utc_time);
   vds_top #(.NV(3)) i_vds_top (.core_clk, .resetn, .bus_req, .rdata, .utc_time,
      .saved_override, .low_supply, .valve_drive, .activity_lamp, .override_lamp,
      .any_open_lamp, .override_saved);
   // ==========================================
   // Shared tasks
   task step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_drv(input logic [2:0] v);
      chk({13'h0000, valve_drive}, {13'h0000, v});
   endtask
   task chk_bit(input logic b, input logic v);
      chk({15'h0000, b}, {15'h0000, v});
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      bus_req <= {a, d, 2'b10};
      @(posedge core_clk);
      bus_req <= '0;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      bus_req <= {a, 16'h0000, 2'b01};
      @(posedge core_clk);
      bus_req <= '0;
      #1;
      chk(rdata, exp);
   endtask
   task wait_chg(input logic [2:0] old);
      int n;
      n = 0;
      while (valve_drive === old && n < 40) begin
         step(1);
         n++;
      end
   endtask
   task do_reset(input logic keep);
      @(posedge core_clk);
      resetn <= 1'b0;
      saved_override <= keep;
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      step(3);
   endtask
   // Monday 21:04 then 21:05, the programmed start
   task match;
      i_vds_utc_src.set_time(5'h15, 6'h04, 3'h1);
      i_vds_utc_src.set_time(5'h15, 6'h05, 3'h1);
   endtask
   // ==========================================
   // Scenarios
   task t_defaults;
      chk_bit(activity_lamp, 1'b1);
      chk_bit(override_lamp, 1'b0);
      rd(`VDS_ADDR_HOUR, 16'h0016);
      rd(`VDS_ADDR_MINUTE, 16'h001E);
      for (int i = 0; i < 3; i++) rd(`VDS_ADDR_LEN0 + 8'(i), 16'h00B4);
      rd(`VDS_ADDR_WEEKDAY, 16'h0202);
      rd(`VDS_ADDR_FORCE, 16'h1000);
      rd(`VDS_ADDR_STATUS, 16'h0000);
      rd(8'h3F, 16'h0000);
   endtask
   task t_sched;
      wr(`VDS_ADDR_WEEKDAY, 16'h8102);
      wr(`VDS_ADDR_FORCE, 16'h0000);
      wr(`VDS_ADDR_HOUR, 16'h0015);
      wr(`VDS_ADDR_MINUTE, 16'h0005);
      for (int i = 0; i < 3; i++) wr(`VDS_ADDR_LEN0 + 8'(i), 16'h0002);
      match();
      wait_chg(3'h0);
      chk_drv(3'h1);
      step(1);
      chk_drv(3'h3);
      step(1);
      chk_drv(3'h7);
      chk_bit(any_open_lamp, 1'b1);
      rd(`VDS_ADDR_STATUS, 16'h0007);
      i_vds_utc_src.tick();
      step(2);
      chk_drv(3'h7);
      i_vds_utc_src.tick();
      wait_chg(3'h7);
      chk_drv(3'h6);
      step(1);
      chk_drv(3'h4);
      step(1);
      chk_drv(3'h0);
      chk_bit(any_open_lamp, 1'b0);
   endtask
   task t_low;
      match();
      wait_chg(3'h0);
      step(2);
      chk_drv(3'h7);
      @(posedge core_clk);
      low_supply <= 1'b1;
      step(2);
      chk_drv(3'h0);
      @(posedge core_clk);
      low_supply <= 1'b0;
      step(4);
      chk_drv(3'h0);
      match();
      wait_chg(3'h0);
      chk_drv(3'h1);
   endtask
   task t_override;
      wr(`VDS_ADDR_CONTROL, 16'h0002);
      step(2);
      chk_bit(override_lamp, 1'b1);
      wr(`VDS_ADDR_FORCE, 16'h0005);
      step(2);
      chk_drv(3'h5);
      match();
      step(8);
      chk_drv(3'h5);
      wr(`VDS_ADDR_FORCE, 16'h0002);
      step(2);
      chk_drv(3'h2);
      wr(`VDS_ADDR_CONTROL, 16'h0000);
      step(3);
      chk_bit(override_lamp, 1'b0);
      chk_drv(3'h0);
   endtask
   task t_clear;
      wr(`VDS_ADDR_FORCE, 16'h1002);
      wr(`VDS_ADDR_CONTROL, 16'h0001);
      rd(`VDS_ADDR_WEEKDAY, 16'h0000);
      rd(`VDS_ADDR_FORCE, 16'h0002);
      rd(`VDS_ADDR_CONTROL, 16'h0000);
      match();
      step(10);
      chk_drv(3'h0);
   endtask
   task t_restart;
      do_reset(1'b1);
      chk_bit(override_lamp, 1'b1);
      rd(`VDS_ADDR_CONTROL, 16'h0002);
      do_reset(1'b0);
      chk_bit(override_lamp, 1'b0);
   endtask
   // ==========================================
   // Run control
   task close_out;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      do_reset(1'b0);
      t_defaults();
      t_sched();
      t_low();
      t_override();
      t_clear();
      t_restart();
      close_out();
   end
   // About sixty times the expected run length
   initial begin
      #100000;
      bad_count++;
      close_out();
   end
endmodule
